// ===== inc/cfs_pkg.sv
// shared constants and types of the capacitor forming sequencer
package cfs_pkg;

  // ---------------------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_PERIOD_NS = 1000000000;
  localparam int TICK_CYC_DEF = TICK_PERIOD_NS / CLK_PERIOD_NS;
  localparam int TICK_W = 27;
  localparam logic [5:0] SEC_PER_MIN = 6'h3C;

  // ---------------------------------------------------------------------------
  // limits
  // ---------------------------------------------------------------------------
  localparam logic [9:0] V_TOL = 10'h00A;
  localparam int PAR_N = 8;
  localparam logic [2:0] P_VBAS = 3'h0;
  localparam logic [2:0] P_IBAS = 3'h1;
  localparam logic [2:0] P_VFIN = 3'h2;
  localparam logic [2:0] P_VSTP = 3'h3;
  localparam logic [2:0] P_IPRF = 3'h4;
  localparam logic [2:0] P_TSTP = 3'h5;
  localparam logic [2:0] P_TFIN = 3'h6;
  localparam logic [2:0] P_TIDL = 3'h7;
  // index 7 down to 0: idle, final hold, step hold, profile I, step V, final V, basic I, basic V
  localparam logic [7:0][9:0] PAR_RST = {10'h03C, 10'h000, 10'h000, 10'h064, 10'h000, 10'h000, 10'h064, 10'h000};
  localparam logic [7:0][9:0] PAR_LO = {10'h001, 10'h000, 10'h000, 10'h064, 10'h000, 10'h000, 10'h064, 10'h000};
  localparam logic [7:0][9:0] PAR_HI = {10'h3E7, 10'h3E7, 10'h3E7, 10'h3E8, 10'h3E8, 10'h3E8, 10'h3E8, 10'h3E8};
  localparam logic [7:0][1:0] PAR_TOPDIG = {2'h2, 2'h2, 2'h2, 2'h3, 2'h3, 2'h3, 2'h3, 2'h3};

  // ---------------------------------------------------------------------------
  // menus
  // ---------------------------------------------------------------------------
  localparam logic [2:0] MAIN_LAST = 3'h4;
  localparam logic [2:0] PRF_LAST = 3'h5;
  localparam logic [2:0] CHG_LAST = 3'h2;
  localparam logic [2:0] M_PRF = 3'h0;
  localparam logic [2:0] M_CHG = 3'h1;
  localparam logic [2:0] M_DIS = 3'h2;
  localparam logic [2:0] M_RES = 3'h3;

  typedef enum logic [10:0] {
    SCR_MAIN = 11'h001,
    SCR_CHG_MENU = 11'h002,
    SCR_PRF_MENU = 11'h004,
    SCR_EDIT = 11'h008,
    SCR_CONFIRM = 11'h010,
    SCR_CHARGING = 11'h020,
    SCR_DIS_CONF = 11'h040,
    SCR_DISCHARGING = 11'h080,
    SCR_RESULTS = 11'h100,
    SCR_IDLE_V = 11'h200,
    SCR_SPARE = 11'h400
  } cfs_screen_type;

  typedef struct packed {
    logic up;
    logic down;
    logic left;
    logic right;
    logic enter;
    logic cancel;
  } cfs_btn_type;

endpackage

// ===== src/cfs_btn_sync.sv
// button and voltage-detect synchroniser with press detection
`timescale 1ns/1ps
module cfs_btn_sync
  import cfs_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic srst_i,
  input wire cfs_pkg::cfs_btn_type btn_i,
  input wire logic vdet_i,
  output cfs_pkg::cfs_btn_type press_o,
  output logic vdet_o
);
  import cfs_pkg::*;

  typedef struct packed {
    logic [6:0] s1;
    logic [6:0] s2;
    logic [6:0] s3;
    logic [6:0] lvl;
    cfs_btn_type press;
  } cfs_sync_type;

  cfs_sync_type st_q, st_d;

  // a bit changes once the second and third stages agree
  always_comb begin
    st_d = st_q;
    st_d.s1 = {vdet_i, btn_i};
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
    st_d.lvl = (st_q.s2 & st_q.s3) | (st_q.lvl & (st_q.s2 | st_q.s3));
    st_d.press = st_d.lvl[5:0] & ~st_q.lvl[5:0];
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign press_o = st_q.press;
  assign vdet_o = st_q.lvl[6];

endmodule // cfs_btn_sync

// ===== src/cfs_sequencer.sv
// menu, charge profile and discharge sequencer of the capacitor former
`timescale 1ns/1ps
// Notes on behaviour
// - profile target rises by step voltage
// - each step target held step hold time
// - final held, then discharge starts automatically
// - target reached within plus minus ten volts
// - step hold limited to 999 minutes
// - final hold limited to 999 units
// - left/right pick digit, up/down change it
// - enter stores edited value, leaves screen
// - menu cursor moves, enter opens line
// - cancel on menu returns to parent
// - cancel while charging starts discharge immediately
// - charging starts only after confirmation
// - manual discharge only after confirmation
// - discharge shows timer, ends on results
// - last measurement result is kept
// - idle timeout switches to voltage screen
// - enter or cancel leaves voltage screen
// - current limit between 100 mA and 1 A
// - voltage setpoints between 0 and 1000 V
// - voltage present output follows detection
module cfs_sequencer
  import cfs_pkg::*;
#(
  parameter int TICK_CYC = TICK_CYC_DEF
) (
  input wire logic clk_sys_i,
  input wire logic srst_i,
  input wire cfs_pkg::cfs_btn_type btn_i,
  input wire logic vdet_i,
  input wire logic [10:0] vload_i,
  input wire logic disch_done_i,
  input wire logic [15:0] meas_i,
  output cfs_pkg::cfs_screen_type screen_o,
  output logic [2:0] cursor_o,
  output logic [1:0] digit_o,
  output logic [9:0] edit_val_o,
  output logic charge_en_o,
  output logic [9:0] target_v_o,
  output logic [9:0] ilim_o,
  output logic discharge_o,
  output logic [15:0] elapsed_o,
  output logic [15:0] result_o,
  output logic vpresent_o
);
  import cfs_pkg::*;

  typedef struct packed {
    cfs_screen_type scr;
    logic prof;
    logic [2:0] cursor;
    logic [1:0] digit;
    logic [2:0] sel;
    logic [9:0] edit_val;
    logic [7:0][9:0] par;
    logic [9:0] target;
    logic [9:0] ilim;
    logic holding;
    logic [15:0] hold_sec;
    logic [TICK_W-1:0] tick_cnt;
    logic [9:0] idle_sec;
    logic [15:0] elapsed;
    logic [15:0] result;
    logic charge_en;
    logic discharge;
    logic vpresent;
  } cfs_state_type;

  cfs_state_type st_q, st_d;
  cfs_btn_type ev;
  logic vdet_s;
  logic tick;
  logic reached;
  logic [15:0] hold_lim;
  logic idle_scr;

  // ---------------------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------------------
  function automatic logic [9:0] dig_weight(input logic [1:0] d);
    case (d)
      2'h0: return 10'h001;
      2'h1: return 10'h00A;
      2'h2: return 10'h064;
      default: return 10'h3E8;
    endcase
  endfunction

  function automatic logic [9:0] edit_step(input logic [9:0] v, input logic [9:0] w, input logic inc,
                                           input logic [9:0] lo, input logic [9:0] hi);
    logic [11:0] s;
    s = {2'h0, v};
    if (inc) begin
      s = {2'h0, v} + {2'h0, w};
      if (s > {2'h0, hi}) begin
        s = {2'h0, hi};
      end
    end else if ({2'h0, v} < {2'h0, lo} + {2'h0, w}) begin
      s = {2'h0, lo};
    end else begin
      s = {2'h0, v} - {2'h0, w};
    end
    return s[9:0];
  endfunction

  function automatic logic [9:0] next_step(input logic [9:0] cur, input logic [9:0] stp, input logic [9:0] fin);
    logic [10:0] s;
    s = {1'b0, cur} + {1'b0, stp};
    if (stp == 10'h000 || s >= {1'b0, fin}) begin
      return fin;
    end
    return s[9:0];
  endfunction

  function automatic cfs_screen_type edit_parent(input logic [2:0] sel);
    if (sel == P_TIDL) begin
      return SCR_MAIN;
    end else if (sel <= P_IBAS) begin
      return SCR_CHG_MENU;
    end
    return SCR_PRF_MENU;
  endfunction

  cfs_btn_sync u_sync (
    .clk_sys_i(clk_sys_i),
    .srst_i(srst_i),
    .btn_i(btn_i),
    .vdet_i(vdet_i),
    .press_o(ev),
    .vdet_o(vdet_s)
  );

  // ---------------------------------------------------------------------------
  // combinational terms
  // ---------------------------------------------------------------------------
  logic [11:0] vdiff;
  always_comb begin
    tick = (st_q.tick_cnt == TICK_W'(TICK_CYC - 1));
    vdiff = ({1'b0, vload_i} >= {2'h0, st_q.target}) ? ({1'b0, vload_i} - {2'h0, st_q.target})
                                                      : ({2'h0, st_q.target} - {1'b0, vload_i});
    reached = (vdiff <= {2'h0, V_TOL});
    hold_lim = 16'((st_q.target == st_q.par[P_VFIN]) ? st_q.par[P_TFIN] : st_q.par[P_TSTP]) * 16'(SEC_PER_MIN);
    idle_scr = (st_q.scr != SCR_CHARGING) && (st_q.scr != SCR_DISCHARGING) && (st_q.scr != SCR_IDLE_V);
  end

  // ---------------------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    st_d.tick_cnt = tick ? '0 : st_q.tick_cnt + 1'b1;
    st_d.vpresent = vdet_s;
    if (ev != '0 || !idle_scr) begin
      st_d.idle_sec = '0;
    end else if (tick && st_q.idle_sec != 10'h3FF) begin
      st_d.idle_sec = st_q.idle_sec + 1'b1;
    end
    case (st_q.scr)
      SCR_MAIN, SCR_CHG_MENU, SCR_PRF_MENU: begin
        if (ev.up && st_q.cursor != 3'h0) begin
          st_d.cursor = st_q.cursor - 1'b1;
        end else if (ev.down && st_q.cursor != (st_q.scr == SCR_MAIN ? MAIN_LAST
                     : st_q.scr == SCR_PRF_MENU ? PRF_LAST : CHG_LAST)) begin
          st_d.cursor = st_q.cursor + 1'b1;
        end
        if (ev.cancel) begin
          st_d.scr = SCR_MAIN;
          st_d.cursor = '0;
        end else if (ev.enter) begin
          st_d.cursor = '0;
          st_d.digit = '0;
          if (st_q.scr == SCR_MAIN) begin
            case (st_q.cursor)
              M_PRF: st_d.scr = SCR_PRF_MENU;
              M_CHG: st_d.scr = SCR_CHG_MENU;
              M_DIS: st_d.scr = SCR_DIS_CONF;
              M_RES: st_d.scr = SCR_RESULTS;
              default: begin
                st_d.scr = SCR_EDIT;
                st_d.sel = P_TIDL;
              end
            endcase
          end else if ((st_q.scr == SCR_PRF_MENU && st_q.cursor == PRF_LAST)
                       || (st_q.scr == SCR_CHG_MENU && st_q.cursor == CHG_LAST)) begin
            st_d.scr = SCR_CONFIRM;
            st_d.prof = (st_q.scr == SCR_PRF_MENU);
          end else begin
            st_d.scr = SCR_EDIT;
            st_d.sel = (st_q.scr == SCR_PRF_MENU) ? st_q.cursor + P_VFIN : st_q.cursor;
          end
          if (st_d.scr == SCR_EDIT) begin
            st_d.edit_val = st_q.par[st_d.sel];
          end
        end
      end
      SCR_EDIT: begin
        if (ev.left && st_q.digit != PAR_TOPDIG[st_q.sel]) begin
          st_d.digit = st_q.digit + 1'b1;
        end else if (ev.right && st_q.digit != 2'h0) begin
          st_d.digit = st_q.digit - 1'b1;
        end else if (ev.up || ev.down) begin
          // clamping keeps every setting in range
          st_d.edit_val = edit_step(st_q.edit_val, dig_weight(st_q.digit), ev.up,
                                    PAR_LO[st_q.sel], PAR_HI[st_q.sel]);
        end
        if (ev.enter) begin
          st_d.par[st_q.sel] = st_q.edit_val;
          st_d.scr = edit_parent(st_q.sel);
          st_d.cursor = '0;
        end else if (ev.cancel) begin
          st_d.scr = edit_parent(st_q.sel);
          st_d.cursor = '0;
        end
      end
      SCR_CONFIRM: begin
        if (ev.enter) begin
          st_d.scr = SCR_CHARGING;
          st_d.charge_en = 1'b1;
          st_d.discharge = 1'b0;
          st_d.holding = 1'b0;
          st_d.hold_sec = '0;
          st_d.target = st_q.prof ? next_step(10'h000, st_q.par[P_VSTP], st_q.par[P_VFIN]) : st_q.par[P_VBAS];
          st_d.ilim = st_q.prof ? st_q.par[P_IPRF] : st_q.par[P_IBAS];
        end else if (ev.cancel) begin
          st_d.scr = st_q.prof ? SCR_PRF_MENU : SCR_CHG_MENU;
        end
      end
      SCR_CHARGING: begin
        if (st_q.prof && !st_q.holding && reached) begin
          st_d.holding = 1'b1;
          st_d.hold_sec = '0;
        end else if (st_q.prof && st_q.holding) begin
          if (st_q.hold_sec >= hold_lim) begin
            if (st_q.target == st_q.par[P_VFIN]) begin
              st_d.scr = SCR_DISCHARGING;
              st_d.charge_en = 1'b0;
              st_d.discharge = 1'b1;
              st_d.elapsed = '0;
            end else begin
              st_d.target = next_step(st_q.target, st_q.par[P_VSTP], st_q.par[P_VFIN]);
              st_d.holding = 1'b0;
            end
          end else if (tick) begin
            st_d.hold_sec = st_q.hold_sec + 1'b1;
          end
        end
        if (ev.cancel) begin
          st_d.scr = SCR_DISCHARGING;
          st_d.charge_en = 1'b0;
          st_d.discharge = 1'b1;
          st_d.elapsed = '0;
        end
      end
      SCR_DIS_CONF: begin
        if (ev.enter) begin
          st_d.scr = SCR_DISCHARGING;
          st_d.discharge = 1'b1;
          st_d.elapsed = '0;
        end else if (ev.cancel) begin
          st_d.scr = SCR_MAIN;
        end
      end
      SCR_DISCHARGING: begin
        if (tick && st_q.elapsed != 16'hFFFF) begin
          st_d.elapsed = st_q.elapsed + 1'b1;
        end
        if (disch_done_i) begin
          st_d.scr = SCR_RESULTS;
          st_d.discharge = 1'b0;
          st_d.result = meas_i;
        end
      end
      SCR_RESULTS, SCR_IDLE_V: begin
        if (ev.enter || ev.cancel) begin
          st_d.scr = SCR_MAIN;
          st_d.cursor = '0;
        end
      end
      default: begin
        st_d.scr = SCR_MAIN;
      end
    endcase
    if (idle_scr && ev == '0 && st_q.idle_sec >= st_q.par[P_TIDL]) begin
      st_d.scr = SCR_IDLE_V;
      st_d.idle_sec = '0;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      st_q <= '0;
      st_q.scr <= SCR_MAIN;
      st_q.par <= PAR_RST;
      st_q.ilim <= PAR_RST[P_IBAS];
    end else begin
      st_q <= st_d;
    end
  end

  assign screen_o = st_q.scr;
  assign cursor_o = st_q.cursor;
  assign digit_o = st_q.digit;
  assign edit_val_o = st_q.edit_val;
  assign charge_en_o = st_q.charge_en;
  assign target_v_o = st_q.target;
  assign ilim_o = st_q.ilim;
  assign discharge_o = st_q.discharge;
  assign elapsed_o = st_q.elapsed;
  assign result_o = st_q.result;
  assign vpresent_o = st_q.vpresent;

  // ---------------------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------------------
  AST_STEP_ADVANCE: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    st_q.scr == SCR_CHARGING && st_q.prof && !ev.cancel && st_q.holding && st_q.hold_sec >= hold_lim
    && st_q.target != st_q.par[P_VFIN] |=> target_v_o > $past(target_v_o) && !st_q.holding)
    else $error("profile target did not advance");
  AST_STEP_HOLD: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    $changed(target_v_o) && st_q.scr == SCR_CHARGING && $past(st_q.scr) == SCR_CHARGING
    |-> $past(st_q.hold_sec) >= $past(hold_lim))
    else $error("step left before hold time");
  AST_FINAL_DISCH: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    st_q.scr == SCR_CHARGING && st_q.prof && st_q.holding && st_q.hold_sec >= hold_lim
    && st_q.target == st_q.par[P_VFIN] |=> discharge_o && !charge_en_o && screen_o == SCR_DISCHARGING)
    else $error("final hold did not end in discharge");
  AST_TOL_WINDOW: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    st_q.scr == SCR_CHARGING && st_q.prof && !st_q.holding && !ev.cancel |=> st_q.holding == $past(reached))
    else $error("tolerance decision wrong");
  AST_CANCEL_ABORT: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    st_q.scr == SCR_CHARGING && ev.cancel |=> discharge_o && !charge_en_o && elapsed_o == 16'h0000)
    else $error("cancel did not abort charge");
  AST_CONFIRM_FIRST: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    $rose(charge_en_o) |-> $past(st_q.scr) == SCR_CONFIRM && $past(ev.enter))
    else $error("charge started without confirmation");
  AST_MAN_DISCH: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    $rose(discharge_o) |-> $past(st_q.scr) inside {SCR_DIS_CONF, SCR_CHARGING})
    else $error("discharge started without cause");
  AST_RESULT_KEEP: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    st_q.scr == SCR_DISCHARGING && disch_done_i |=> screen_o == SCR_RESULTS && result_o == $past(meas_i)
    ##1 result_o == $past(result_o))
    else $error("result not latched or not kept");
  AST_IDLE_TO: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    idle_scr && ev == '0 && st_q.idle_sec >= st_q.par[P_TIDL] |=> screen_o == SCR_IDLE_V)
    else $error("idle timeout missed");
  AST_ILIM_RANGE: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    ilim_o >= PAR_LO[P_IBAS] && ilim_o <= PAR_HI[P_IBAS] && target_v_o <= PAR_HI[P_VBAS])
    else $error("setpoint out of range");
  AST_VPRESENT: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    vpresent_o == $past(vdet_s))
    else $error("voltage present not shown");

endmodule // cfs_sequencer

// ===== verif/cfs_load_model.sv
// behavioural load and measurement front end seen by the sequencer
`timescale 1ns/1ps
module cfs_load_model
  import cfs_pkg::*;
#(
  parameter int DIS_CYC = 35
) (
  input wire logic clk_sys_i,
  input wire logic srst_i,
  input wire logic charge_en_i,
  input wire logic discharge_i,
  input wire logic [9:0] target_v_i,
  output logic [10:0] vload_o,
  output logic vdet_o,
  output logic disch_done_o
);
  logic [10:0] vload_q;
  logic [15:0] dcnt_q;
  logic [10:0] settle;

  // ---------------------------------------------------------------------------
  // load voltage
  // ---------------------------------------------------------------------------
  // settles 8 V short of target so only a tolerant comparison sees it reached
  assign settle = {1'b0, target_v_i} - 11'h008;
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      vload_q <= 11'h000;
      dcnt_q <= 16'h0000;
    end else begin
      if (charge_en_i && vload_q < settle) begin
        vload_q <= vload_q + 11'h001;
      end else if (discharge_i) begin
        vload_q <= (vload_q > 11'h004) ? vload_q - 11'h004 : 11'h000;
      end
      dcnt_q <= discharge_i ? dcnt_q + 16'h0001 : 16'h0000;
    end
  end

  assign vload_o = vload_q;
  assign vdet_o = (vload_q > 11'h032);
  // done level stays up until the sequencer drops its discharge enable
  assign disch_done_o = discharge_i && (dcnt_q >= 16'(DIS_CYC));
endmodule // cfs_load_model

// ===== verif/tb_top.sv
// self-checking bench of the capacitor forming sequencer
`timescale 1ns/1ps
module tb_top;
  import cfs_pkg::*;
  localparam int B_UP = 5;
  localparam int B_DN = 4;
  localparam int B_LF = 3;
  localparam int B_RT = 2;
  localparam int B_EN = 1;
  localparam int B_CN = 0;
  logic clk_sys_i;
  logic srst_i;
  logic [5:0] btn_raw;
  logic [15:0] meas;
  logic vdet;
  logic done;
  logic [10:0] vload;
  cfs_screen_type scr;
  logic [2:0] cursor;
  logic [1:0] digit;
  logic [9:0] edit_val;
  logic [9:0] target_v;
  logic [9:0] ilim;
  logic charge_en;
  logic discharge;
  logic vpresent;
  logic [15:0] elapsed;
  logic [15:0] result;
  int mismatches;
  int checked;
  int n;

  cfs_sequencer #(.TICK_CYC(10)) DUT (
    .clk_sys_i(clk_sys_i), .srst_i(srst_i), .btn_i(cfs_btn_type'(btn_raw)), .vdet_i(vdet),
    .vload_i(vload), .disch_done_i(done), .meas_i(meas), .screen_o(scr), .cursor_o(cursor),
    .digit_o(digit), .edit_val_o(edit_val), .charge_en_o(charge_en), .target_v_o(target_v),
    .ilim_o(ilim), .discharge_o(discharge), .elapsed_o(elapsed), .result_o(result), .vpresent_o(vpresent)
  );

  cfs_load_model LOAD (
    .clk_sys_i(clk_sys_i), .srst_i(srst_i), .charge_en_i(charge_en), .discharge_i(discharge),
    .target_v_i(target_v), .vload_o(vload), .vdet_o(vdet), .disch_done_o(done)
  );

  initial begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end

  // ---------------------------------------------------------------------------
  // access tasks
  // ---------------------------------------------------------------------------
  task automatic step(input int c);
    repeat (c) @(posedge clk_sys_i);
    #1;
  endtask

  // press and release, long enough for the synchroniser and the screen update
  task automatic press(input int b);
    btn_raw[b] = 1'b1;
    step(3);
    btn_raw[b] = 1'b0;
    step(4);
  endtask

  task automatic open_line(input int k);
    repeat (k) press(B_DN);
    press(B_EN);
  endtask

  task automatic close_out();
    $display("counts: checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic cmp_val(input logic [15:0] got, input logic [15:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic cmp_scr(input cfs_screen_type got, input cfs_screen_type exp, input string what);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t %s screen %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic wait_scr(input cfs_screen_type s, input int lim, output int cnt);
    cnt = 0;
    while (scr !== s && cnt < lim) begin
      step(1);
      cnt++;
    end
    if (scr !== s) begin
      mismatches++;
      $display("MISMATCH t=%0t wait for screen %h ran out", $time, s);
      close_out();
    end
  endtask

  // ---------------------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------------------
  initial begin
    btn_raw = 6'h00;
    meas = 16'h0000;
    srst_i = 1'b1;
    mismatches = 0;
    checked = 0;
    step(2);
    srst_i = 1'b0;
    cmp_scr(scr, SCR_MAIN, "reset screen");
    cmp_val(16'(ilim), 16'h0064, "reset ilim");
    cmp_val({13'h0000, charge_en, discharge, vpresent}, 16'h0000, "reset enables");
    cmp_val(result, 16'h0000, "reset result");
    $display("test reset done");

    repeat (6) press(B_DN);
    cmp_val(16'(cursor), 16'h0004, "cursor bottom");
    repeat (6) press(B_UP);
    cmp_val(16'(cursor), 16'h0000, "cursor top");
    open_line(1);
    cmp_scr(scr, SCR_CHG_MENU, "open charge menu");
    press(B_CN);
    cmp_scr(scr, SCR_MAIN, "cancel to parent");
    $display("test menus done");

    open_line(1);
    open_line(0);
    press(B_LF);
    press(B_UP);
    cmp_val(16'(edit_val), 16'h000A, "tens up");
    repeat (3) press(B_LF);
    cmp_val(16'(digit), 16'h0003, "digit top");
    press(B_UP);
    cmp_val(16'(edit_val), 16'h03E8, "voltage clamp");
    press(B_RT);
    cmp_val(16'(digit), 16'h0002, "digit right");
    press(B_EN);
    cmp_scr(scr, SCR_CHG_MENU, "enter leaves edit");
    open_line(1);
    press(B_DN);
    cmp_val(16'(edit_val), 16'h0064, "current low clamp");
    repeat (3) press(B_LF);
    press(B_UP);
    cmp_val(16'(edit_val), 16'h03E8, "current high clamp");
    press(B_EN);
    open_line(2);
    cmp_scr(scr, SCR_CONFIRM, "confirm screen");
    cmp_val({15'h0000, charge_en}, 16'h0000, "no output before confirm");
    press(B_EN);
    cmp_scr(scr, SCR_CHARGING, "charging");
    cmp_val({charge_en, 5'h00, target_v}, 16'h83E8, "basic target stored");
    cmp_val(16'(ilim), 16'h03E8, "current stored");
    step(100);
    cmp_val({15'h0000, vpresent}, 16'h0001, "voltage lamp");
    meas = 16'h1234;
    press(B_CN);
    cmp_val({14'h0000, charge_en, discharge}, 16'h0001, "cancel discharges");
    wait_scr(SCR_RESULTS, 100, n);
    cmp_val(result, 16'h1234, "result kept");
    press(B_EN);
    open_line(3);
    cmp_val(result, 16'h1234, "result shown again");
    press(B_CN);
    $display("test basic charge done");

    open_line(0);
    for (int k = 3; k <= 4; k++) begin
      open_line(k);
      repeat (2) press(B_LF);
      repeat (10) press(B_UP);
      cmp_val(16'(edit_val), 16'h03E7, "hold clamp");
      press(B_CN);
      cmp_scr(scr, SCR_PRF_MENU, "edit cancel");
    end
    open_line(0);
    press(B_LF);
    repeat (3) press(B_UP);
    press(B_EN);
    open_line(1);
    press(B_LF);
    repeat (2) press(B_UP);
    press(B_EN);
    open_line(3);
    press(B_UP);
    press(B_EN);
    open_line(4);
    repeat (2) press(B_UP);
    press(B_EN);
    meas = 16'h0ABC;
    open_line(5);
    press(B_EN);
    cmp_val(16'(target_v), 16'h0014, "first step");
    step(300);
    cmp_val(16'(target_v), 16'h0014, "step held");
    step(400);
    cmp_val(16'(target_v), 16'h001E, "next step");
    wait_scr(SCR_DISCHARGING, 1400, n);
    cmp_val({15'h0000, (n >= 1050 && n <= 1200)}, 16'h0001, "final hold length");
    cmp_val({14'h0000, charge_en, discharge}, 16'h0001, "auto discharge");
    wait_scr(SCR_RESULTS, 100, n);
    cmp_val(result, 16'h0ABC, "profile result");
    $display("test profile done");

    press(B_EN);
    open_line(2);
    cmp_scr(scr, SCR_DIS_CONF, "discharge confirm");
    cmp_val({15'h0000, discharge}, 16'h0000, "no discharge before confirm");
    meas = 16'h0042;
    press(B_EN);
    cmp_val({15'h0000, discharge}, 16'h0001, "discharge started");
    step(25);
    cmp_val({15'h0000, |elapsed}, 16'h0001, "timer runs");
    wait_scr(SCR_RESULTS, 100, n);
    cmp_val(result, 16'h0042, "manual result");
    $display("test discharge done");

    press(B_CN);
    open_line(4);
    cmp_scr(scr, SCR_EDIT, "settings screen");
    cmp_val(16'(edit_val), 16'h003C, "idle timeout default");
    press(B_CN);
    cmp_scr(scr, SCR_MAIN, "settings cancel");
    wait_scr(SCR_IDLE_V, 800, n);
    cmp_val({15'h0000, (n >= 585 && n <= 605)}, 16'h0001, "idle timeout length");
    press(B_CN);
    cmp_scr(scr, SCR_MAIN, "cancel leaves idle");
    wait_scr(SCR_IDLE_V, 800, n);
    press(B_EN);
    cmp_scr(scr, SCR_MAIN, "enter leaves idle");
    $display("test idle done");
    close_out();
  end
endmodule // tb_top
